// *** pkg/wsup_pkg.sv ***
// Package of constants and types for the window supervisor block.
package wsup_pkg;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam logic [7:0] WSUP_CTRL_OFFSET = 8'h2a;
	localparam logic [7:0] WSUP_WIN_OFFSET = 8'h2b;
	localparam int WSUP_ARM_BIT = 7;
	localparam int WSUP_TOP_BIT = 6;
	localparam int WSUP_CNT_W = 7;
	localparam logic [6:0] WSUP_CNT_RESET = 7'h7f;
	localparam logic [6:0] WSUP_WIN_RESET = 7'h7f;
	localparam logic WSUP_ARM_RESET = 1'b0;
	localparam logic [6:0] WSUP_CNT_EXPIRE = 7'h40;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int WSUP_CLK_PERIOD_NS = 10;
	localparam int WSUP_PRESCALE_DEF = 16384;
	localparam int WSUP_PRESCALE_W = 14;
	localparam int WSUP_RESET_PULSE_NS = 30000;
	localparam int WSUP_RESET_PULSE_CYCLES = WSUP_RESET_PULSE_NS / WSUP_CLK_PERIOD_NS;
	localparam int WSUP_PULSE_W = 12;
	localparam int WSUP_PHASE_STEP = 64;

	// Prescaler phase offset per timebase selection, in steps of 64 cycles.
	localparam logic [3:0][5:0] WSUP_TB_PHASE = {6'd54, 6'd35, 6'd53, 6'd59};

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wsup_bus_req_t;

	typedef struct packed {
		logic hw_activate;
		logic halt_reset_option;
	} wsup_options_t;

endpackage : wsup_pkg

// *** rtl/wsup_prescaler.sv ***
// Free-running prescaler that issues one decrement enable per period.
`timescale 1ns/1ps

module wsup_prescaler #(
	parameter int PERIOD = wsup_pkg::WSUP_PRESCALE_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [1:0] i_timebase_select,
	output logic o_tick,
	output logic [wsup_pkg::WSUP_PRESCALE_W-1:0] o_phase
);
	import wsup_pkg::*;

	localparam logic [WSUP_PRESCALE_W-1:0] LAST = WSUP_PRESCALE_W'(PERIOD - 1);

	logic [WSUP_PRESCALE_W-1:0] phase_q;
	logic [1:0] tb_q;
	logic loaded_q;
	logic tick_q;
	logic [WSUP_PRESCALE_W-1:0] offset;

	// Offset scaled to the period so that a shortened period keeps the same relation.
	always_comb
	begin
		offset = WSUP_PRESCALE_W'((int'(WSUP_TB_PHASE[i_timebase_select]) * WSUP_PHASE_STEP
			* PERIOD) / WSUP_PRESCALE_DEF);
	end

	// ----------------------------------------------------------------
	// Phase counter
	// ----------------------------------------------------------------
	// The phase is never cleared by register writes; only the timebase moves it.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			phase_q <= '0;
			tb_q <= 2'h0;
			loaded_q <= 1'b0;
		end
		else if (!loaded_q || tb_q != i_timebase_select)
		begin
			phase_q <= offset;
			tb_q <= i_timebase_select;
			loaded_q <= 1'b1;
		end
		else if (phase_q == LAST)
		begin
			phase_q <= '0;
		end
		else
		begin
			phase_q <= phase_q + 1'b1;
		end
	end

	// Enable pulse one cycle wide, registered so consumers see a clean level.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= loaded_q && (tb_q == i_timebase_select) && (phase_q == LAST);
		end
	end

	assign o_tick = tick_q;
	assign o_phase = phase_q;

endmodule : wsup_prescaler

// *** rtl/wsup_top.sv ***
// Window supervisor: free-running downcounter with window check and reset pulse.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

module wsup_top #(
	parameter int PRESCALE_CYCLES = wsup_pkg::WSUP_PRESCALE_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wsup_pkg::wsup_bus_req_t i_bus,
	output logic [7:0] o_rdata,
	input wsup_pkg::wsup_options_t i_options,
	input wire logic [1:0] i_timebase_select,
	input wire logic i_halt_req,
	output logic o_halt_enter,
	output logic o_reset_pin_o,
	output logic o_reset_pin_oe_n,
	output logic o_reset_active
);
	import wsup_pkg::*;

	localparam logic [WSUP_PULSE_W-1:0] PULSE_LAST = WSUP_PULSE_W'(WSUP_RESET_PULSE_CYCLES - 1);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic supervisor_arm_bit_q;
	logic [6:0] programmed_count_q;
	logic [6:0] window_q;
	logic [7:0] rdata_q;
	logic pulse_q;
	logic [WSUP_PULSE_W-1:0] pulse_cnt_q;
	logic oe_n_q;
	logic halt_enter_q;
	logic tick;
	logic [WSUP_PRESCALE_W-1:0] phase;
	logic wr_ctrl;
	logic wr_win;
	logic active;
	logic arm_d;
	logic active_d;
	logic expire_hit;
	logic early_hit;
	logic soft_hit;
	logic halt_hit;
	logic trigger;

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	wsup_prescaler #(
		.PERIOD(PRESCALE_CYCLES)
	) u_prescaler (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_timebase_select(i_timebase_select),
		.o_tick(tick),
		.o_phase(phase)
	);

	// ----------------------------------------------------------------
	// Decode and reset causes
	// ----------------------------------------------------------------
	// Address decode of the two registers; other addresses store nothing.
	always_comb
	begin
		wr_ctrl = 1'b0;
		wr_win = 1'b0;
		if (i_bus.wr && i_bus.addr == WSUP_CTRL_OFFSET)
		begin
			wr_ctrl = 1'b1;
		end
		else if (i_bus.wr && i_bus.addr == WSUP_WIN_OFFSET)
		begin
			wr_win = 1'b1;
		end
	end

	// A written zero never clears the arm bit; once set, only a reset cycle clears it.
	assign arm_d = supervisor_arm_bit_q | (wr_ctrl & i_bus.wdata[WSUP_ARM_BIT]);
	assign active = supervisor_arm_bit_q | i_options.hw_activate;
	assign active_d = arm_d | i_options.hw_activate;

	// Rollover from 40h to 3Fh, unless a reload lands in the same cycle.
	assign expire_hit = active && tick && !wr_ctrl
		&& programmed_count_q == WSUP_CNT_EXPIRE;
	// Reload while still above the window value.
	assign early_hit = active_d && wr_ctrl && (programmed_count_q > window_q);
	// Writing the top bit clear while armed forces a reset at once.
	assign soft_hit = active_d && wr_ctrl && !i_bus.wdata[WSUP_TOP_BIT];
	assign halt_hit = active && i_halt_req && i_options.halt_reset_option;
	assign trigger = !pulse_q && (expire_hit || early_hit || soft_hit || halt_hit);

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	// The counter runs free whether or not it is armed; a reset cycle reloads defaults,
	// as the rest of the chip is reset with it.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			supervisor_arm_bit_q <= WSUP_ARM_RESET;
			programmed_count_q <= WSUP_CNT_RESET;
		end
		else if (trigger)
		begin
			supervisor_arm_bit_q <= WSUP_ARM_RESET;
			programmed_count_q <= WSUP_CNT_RESET;
		end
		else if (wr_ctrl)
		begin
			supervisor_arm_bit_q <= arm_d;
			programmed_count_q <= i_bus.wdata[WSUP_CNT_W-1:0];
		end
		else if (tick)
		begin
			programmed_count_q <= programmed_count_q - 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Window register
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			window_q <= WSUP_WIN_RESET;
		end
		else if (trigger)
		begin
			window_q <= WSUP_WIN_RESET;
		end
		else if (wr_win)
		begin
			window_q <= i_bus.wdata[WSUP_CNT_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	// Read data stand one cycle after the strobe and return to zero after.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rdata_q <= 8'h00;
		end
		else if (i_bus.rd && i_bus.addr == WSUP_CTRL_OFFSET)
		begin
			rdata_q <= {supervisor_arm_bit_q, programmed_count_q};
		end
		else if (i_bus.rd && i_bus.addr == WSUP_WIN_OFFSET)
		begin
			rdata_q <= {1'b0, window_q};
		end
		else
		begin
			rdata_q <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Reset pulse
	// ----------------------------------------------------------------
	// Further causes during a pulse are ignored; the pulse length is fixed.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pulse_q <= 1'b0;
			pulse_cnt_q <= '0;
			oe_n_q <= 1'b1;
		end
		else if (trigger)
		begin
			pulse_q <= 1'b1;
			pulse_cnt_q <= '0;
			oe_n_q <= 1'b0;
		end
		else if (pulse_q && pulse_cnt_q == PULSE_LAST)
		begin
			pulse_q <= 1'b0;
			pulse_cnt_q <= '0;
			oe_n_q <= 1'b1;
		end
		else if (pulse_q)
		begin
			pulse_cnt_q <= pulse_cnt_q + 1'b1;
		end
	end

	// Halt is granted only when it does not turn into a reset.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			halt_enter_q <= 1'b0;
		end
		else
		begin
			halt_enter_q <= i_halt_req && !halt_hit && !pulse_q;
		end
	end

	assign o_rdata = rdata_q;
	assign o_halt_enter = halt_enter_q;
	assign o_reset_pin_o = 1'b0 & oe_n_q; // Open drain: only ever drives low.
	assign o_reset_pin_oe_n = oe_n_q;
	assign o_reset_active = pulse_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_tick_decrement: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		tick && !wr_ctrl && !trigger |=> programmed_count_q == $past(programmed_count_q) - 7'h01)
		else $error("count did not decrement on tick");

	chk_expire_reset: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		!pulse_q && tick && !wr_ctrl && active && programmed_count_q == WSUP_CNT_EXPIRE
		|=> pulse_q && !o_reset_pin_oe_n && programmed_count_q == WSUP_CNT_RESET)
		else $error("rollover while armed gave no reset");

	chk_early_reload: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		!pulse_q && wr_ctrl && active_d && programmed_count_q > window_q |=> pulse_q)
		else $error("early reload gave no reset");

	chk_arm_sticky: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		supervisor_arm_bit_q && !trigger |=> supervisor_arm_bit_q)
		else $error("arm bit cleared without reset");

	chk_idle_no_reset: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		!pulse_q && !active_d && !i_options.hw_activate |=> !pulse_q)
		else $error("reset while disarmed");

	chk_soft_reset: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		!pulse_q && wr_ctrl && i_bus.wdata[WSUP_ARM_BIT] && !i_bus.wdata[WSUP_TOP_BIT]
		|=> pulse_q [*2])
		else $error("software reset not issued");

	chk_halt_reset: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		!pulse_q && i_halt_req && active && i_options.halt_reset_option
		|=> pulse_q && !halt_enter_q)
		else $error("halt while armed did not reset");

	chk_pulse_length: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		$fell(pulse_q) |-> $past(pulse_cnt_q) == PULSE_LAST)
		else $error("reset pulse length wrong");

	chk_phase_kept: assert property (
		@(posedge i_ref_clk) disable iff (!i_reset_n)
		wr_ctrl && $stable(i_timebase_select) && phase != 14'h0000
		|=> phase == $past(phase) + 14'h0001 || phase == 14'h0000)
		else $error("prescaler phase disturbed by write");

endmodule : wsup_top

// *** tb/test_window_watchdog.sv ***
// Self-checking testbench for the window supervisor block.
`timescale 1ns/1ps

module test_window_watchdog;
	import wsup_pkg::*;

	localparam int PER = 64;
	logic i_ref_clk = 1'b0;
	logic i_reset_n = 1'b0;
	wsup_bus_req_t bus;
	wsup_options_t opt = 2'b00;
	logic [1:0] tb_sel = 2'b00;
	logic halt_req;
	logic [7:0] rdata;
	logic halt_enter;
	logic pin_o;
	logic pin_oe_n;
	logic rst_act;
	logic [7:0] got;
	int mismatches = 0;
	int n_checks = 0;
	int n;

	// Free-running 100 MHz clock.
	always #5 i_ref_clk = ~i_ref_clk;

	// A short prescaler keeps each count step at 64 cycles.
	wsup_top #(.PRESCALE_CYCLES(PER)) i_wsup_top (.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata), .i_options(opt),
		.i_timebase_select(tb_sel), .i_halt_req(halt_req), .o_halt_enter(halt_enter),
		.o_reset_pin_o(pin_o), .o_reset_pin_oe_n(pin_oe_n), .o_reset_active(rst_act));

	wsup_cpu_model i_wsup_cpu_model (.i_ref_clk(i_ref_clk), .i_rdata(rdata),
		.o_bus(bus), .o_halt_req(halt_req));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_wsup_cpu_model.access(a, d, 1'b1);
	endtask : wr

	// A decrement may land between request and answer, so one less passes.
	task automatic check_ctrl(input logic [7:0] e);
		i_wsup_cpu_model.read_reg(WSUP_CTRL_OFFSET, got);
		check(got, (got === e - 8'h01) ? got : e);
	endtask : check_ctrl

	// Count cycles until the reset pulse shows, with a bound.
	task automatic wait_rst(input int lim);
		n = 0;
		while (rst_act !== 1'b1 && n < lim)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
	endtask : wait_rst

	// Measure a running pulse. The registers restart from reset values as it begins,
	// and the free-running count keeps stepping for the whole pulse.
	task automatic pulse();
		check({pin_oe_n, pin_o, rst_act}, 3'b001);
		n = 0;
		while (rst_act === 1'b1 && n < 4000)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		check(16'(n), 16'(WSUP_RESET_PULSE_CYCLES));
		check(pin_oe_n, 1'b1);
		check_ctrl(8'(WSUP_CNT_RESET) - 8'(WSUP_RESET_PULSE_CYCLES / PER));
	endtask : pulse

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	// Hang guard, sized well above the seven pulses of 3000 cycles each.
	initial
	begin
		repeat (60000) @(posedge i_ref_clk);
		mismatches++;
		complete_run();
	end

	initial
	begin
		repeat (3) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		check_ctrl(8'h7f);
		wr(WSUP_WIN_OFFSET, 8'hff);
		i_wsup_cpu_model.read_reg(WSUP_WIN_OFFSET, got);
		check(got, 8'h7f);
		i_wsup_cpu_model.read_reg(8'h2c, got);
		check(got, 8'h00);
		$display("test registers done");
		// Unarmed: each timebase phase puts four steps into the 256 cycles after a write.
		// A prescaler cleared by the write, or one that ignored the timebase, shows three.
		for (int t = 0; t < 4; t++)
		begin
			@(posedge i_ref_clk);
			tb_sel <= 2'(t);
			wr(WSUP_CTRL_OFFSET, 8'h7f);
			repeat (254) @(posedge i_ref_clk);
			i_wsup_cpu_model.read_reg(WSUP_CTRL_OFFSET, got);
			check(got, 8'h7b);
		end
		wr(WSUP_CTRL_OFFSET, 8'h41);
		repeat (254) @(posedge i_ref_clk);
		check_ctrl(8'h3e);
		check(rst_act, 1'b0);
		$display("test free count done");
		// Armed timeout after the programmed number of steps.
		for (int s = 0; s < 3; s++)
		begin
			wr(WSUP_CTRL_OFFSET, {2'b11, 6'(s)});
			wait_rst(300);
			check(n > s * PER && n <= (s + 1) * PER + 2, 1'b1);
			pulse();
		end
		$display("test timeout done");
		// Arm bit survives a written zero; reloads inside and above the window.
		wr(WSUP_CTRL_OFFSET, 8'hc8);
		wr(WSUP_CTRL_OFFSET, 8'h48);
		check_ctrl(8'hc8);
		i_wsup_cpu_model.refresh(6'h08);
		#1;
		check(rst_act, 1'b0);
		wr(WSUP_WIN_OFFSET, 8'h45);
		wr(WSUP_CTRL_OFFSET, 8'hff);
		#1;
		check(rst_act, 1'b1);
		pulse();
		wr(WSUP_CTRL_OFFSET, 8'h80);
		#1;
		check(rst_act, 1'b1);
		pulse();
		$display("test window done");
		// Hardware activation arms the block with the arm bit clear.
		@(posedge i_ref_clk);
		opt <= 2'b10;
		wr(WSUP_CTRL_OFFSET, 8'h3f);
		#1;
		check(rst_act, 1'b1);
		pulse();
		@(posedge i_ref_clk);
		opt <= 2'b00;
		i_wsup_cpu_model.halt();
		#1;
		check({halt_enter, rst_act}, 2'b10);
		@(posedge i_ref_clk);
		opt <= 2'b01;
		// Load below the window so that the refresh before halting is a legal one.
		wr(WSUP_CTRL_OFFSET, 8'hfe);
		i_wsup_cpu_model.halt();
		#1;
		check({halt_enter, rst_act}, 2'b01);
		pulse();
		$display("test modes done");
		complete_run();
	end

endmodule : test_window_watchdog

// *** tb/wsup_cpu_model.sv ***
// CPU-side model that drives the supervisor register port and halt requests.
`timescale 1ns/1ps

module wsup_cpu_model (
	input wire logic i_ref_clk,
	input wire logic [7:0] i_rdata,
	output wsup_pkg::wsup_bus_req_t o_bus,
	output logic o_halt_req
);
	import wsup_pkg::*;

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	// The bus idles from time zero, so nothing reaches the block in reset.
	initial
	begin
		o_bus = '0;
		o_halt_req = 1'b0;
	end

	// One strobe cycle, held until the edge that takes it.
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge i_ref_clk);
		o_bus <= '{a, d, w, !w};
		@(posedge i_ref_clk);
		o_bus <= '0;
	endtask : access

	// Read data stand only in the cycle after the strobe.
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		access(a, 8'h00, 1'b0);
		#1;
		d = i_rdata;
	endtask : read_reg

	// ----------------------------------------------------------------
	// Software habits
	// ----------------------------------------------------------------
	// Reload only inside the window, always with the top count bit set.
	task automatic refresh(input logic [5:0] steps);
		logic [7:0] c;
		logic [7:0] w;
		read_reg(WSUP_CTRL_OFFSET, c);
		read_reg(WSUP_WIN_OFFSET, w);
		if (c[6:0] < w[6:0] && c[6])
			access(WSUP_CTRL_OFFSET, {2'b11, steps}, 1'b1);
	endtask : refresh

	// A refresh just before halting avoids an early timeout after wake-up.
	task automatic halt();
		refresh(6'h3f);
		@(posedge i_ref_clk);
		o_halt_req <= 1'b1;
		@(posedge i_ref_clk);
		o_halt_req <= 1'b0;
	endtask : halt

endmodule : wsup_cpu_model
